// *** rtl/tpp_pkg.sv ***
// Purpose: shared constants and types for the dual-slope pwm timer
// Assumes: ahb-lite slave, 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package tpp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  // control a fields
  localparam int CA_MODE_A_HI = 7;
  localparam int CA_MODE_A_LO = 6;
  localparam int CA_MODE_B_HI = 5;
  localparam int CA_MODE_B_LO = 4;
  localparam int CA_WAVE_HI = 1;
  localparam int CA_WAVE_LO = 0;
  localparam logic [7:0] CA_WMASK = 8'hf3;
  // control b fields
  localparam int CB_WAVE_HIGH = 3;
  localparam int CB_CS_HI = 2;
  localparam logic [7:0] CB_WMASK = 8'h0f;
  // flag bits
  localparam int FL_OVF = 0;
  localparam int FL_MA = 1;
  localparam int FL_MB = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // phase correct wave modes and period in ticks
  localparam logic [2:0] WM_PC_FIXED = 3'h1;
  localparam logic [2:0] WM_PC_CMPA = 3'h5;
  localparam int PC_PERIOD_TICKS = 510;
  // prescale divisors
  localparam int PS_1 = 1;
  localparam int PS_8 = 8;
  localparam int PS_64 = 64;
  localparam int PS_256 = 256;
  localparam int PS_1024 = 1024;
  localparam int PS_W = 10;
  // output mode codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  // ahb transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ahb request as carried into the slave
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } tpp_req_s;

  // waveform unit event strobes for one channel
  typedef struct packed {
    logic match;
    logic up;
    logic at_top;
    logic at_bottom;
  } tpp_evt_s;
endpackage

// *** rtl/tpp_wave_unit.sv ***
// Purpose: one compare output channel of the pwm timer
// Assumes: events arrive qualified by the timer tick
// Notes: channel a enables toggle; channel b treats code 1 as off
`timescale 1ns/10ps
module tpp_wave_unit #(
  parameter bit TOGGLE_OK = 1'b1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic [2:0] wave_mode,
  input wire logic [1:0] out_mode,
  input wire logic [7:0] cmp_val,
  input wire logic [7:0] top_val,
  input wire logic [7:0] count_q,
  input wire logic up_q,
  input wire logic wr_cmp,
  output logic wave_out,
  output logic connected
);
  logic wave_q;
  logic wave_d;
  logic [7:0] cmp_prev_q;
  logic pc_mode;
  logic fast_mode;
  logic match;
  logic at_top;
  logic at_bottom;
  logic ignore_match;
  logic toggle_on;
  logic up_level;
  logic missed;

  //////////////////////////////////////////////////////////////////////////
  // mode decode
  assign pc_mode = (wave_mode == tpp_pkg::WM_PC_FIXED) ||
                   (wave_mode == tpp_pkg::WM_PC_CMPA);
  assign fast_mode = (wave_mode[1:0] == 2'h3);
  assign match = tick && (count_q == cmp_val);
  assign at_top = tick && (count_q == top_val);
  assign at_bottom = tick && (count_q == tpp_pkg::CNT_BOTTOM);
  // compare at top with upper mode bit: match ignored, top action kept
  assign ignore_match = (cmp_val == top_val) && out_mode[1];
  // toggle only for channel a with the high wave bit in pwm modes
  assign toggle_on = (out_mode == tpp_pkg::OM_TOGGLE) &&
                     (TOGGLE_OK && (wave_mode[2] || !(pc_mode || fast_mode)));
  assign connected = (out_mode != tpp_pkg::OM_OFF) &&
                     (out_mode[1] || toggle_on);
  // level left by an up-counting match: low for code 2, high for code 3
  assign up_level = (out_mode == tpp_pkg::OM_SET);
  // bottom fix-up: compare left max, or up-match missed so the level
  // below the compare was never restored; bottom must show that level
  assign missed = (cmp_prev_q == tpp_pkg::CNT_MAX) ||
                  (wave_q == up_level);

  //////////////////////////////////////////////////////////////////////////
  // output level next state
  always_comb
  begin
    wave_d = wave_q;
    if (toggle_on)
    begin
      if (match)
        wave_d = !wave_q;
    end
    else if (out_mode[1] && pc_mode)
    begin
      if (cmp_val == tpp_pkg::CNT_BOTTOM)
        wave_d = up_level;
      else if (cmp_val == tpp_pkg::CNT_MAX ||
               (cmp_val == top_val && at_top))
        wave_d = !up_level;
      else if (match && up_q)
        wave_d = up_level;
      else if (match && !up_q)
        wave_d = !up_level;
      else if (at_bottom && missed)
        wave_d = !up_level;
    end
    else if (out_mode[1] && fast_mode)
    begin
      if (at_top)
        wave_d = !up_level;
      else if (match && !ignore_match)
        wave_d = up_level;
    end
    else if (out_mode[1] && match)
      wave_d = up_level;
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wave_q <= 1'b0;
      cmp_prev_q <= tpp_pkg::CNT_BOTTOM;
    end
    else
    begin
      wave_q <= wave_d;
      if (at_bottom || wr_cmp)
        cmp_prev_q <= cmp_val;
    end
  end

  assign wave_out = wave_q;
endmodule

// *** rtl/tpp_timer.sv ***
// Purpose: 8-bit timer with dual-slope phase correct pwm and two outputs
// Assumes: ahb-lite single word transfers, zero wait states
// Notes: compare registers double buffered, updated at top in pwm modes
//
// Function
// - phase correct when wave mode 1 or 5
// - count up to top, then down
// - top is max or compare a
// - non-inverting clears up, sets down
// - hold top for one tick
// - overflow flag set at bottom
// - output a toggle needs high wave bit
// - nonzero out mode overrides port pin; code 1 stays off for b, and for a in pwm modes without the high wave bit
// - compare bottom low, max high
// - compare leaving max transitions at bottom
// - missed up match fixed at bottom
// - period 510 ticks, five prescale choices
// - synchronous, tick is clock enable
// - control a field layout, reserved zero
// - non-pwm out mode codes
// - single-slope pwm set/clear at top
// - phase correct code 2 and 3
// - compare equal top ignores match
// - high wave bit from control b
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module tpp_timer #(
  parameter int PRESCALE_W = tpp_pkg::PS_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic wave_out_a,
  output logic wave_out_a_en,
  output logic wave_out_b,
  output logic wave_out_b_en,
  output logic overflow_flag
);
  tpp_pkg::tpp_req_s req_q;
  logic req_valid_q;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] count_value_q;
  logic [7:0] count_value_d;
  logic [7:0] cmp_a_buf_q;
  logic [7:0] cmp_b_buf_q;
  logic [7:0] compare_a_value_q;
  logic [7:0] compare_b_value_q;
  logic up_q;
  logic up_d;
  logic [2:0] flags_q;
  logic [PRESCALE_W-1:0] pre_q;
  logic [31:0] rdata_q;
  logic [2:0] wave_mode;
  logic [2:0] clk_sel;
  logic pc_mode;
  logic dbuf_mode;
  logic [7:0] top_val;
  logic timer_tick;
  logic at_top;
  logic at_bottom;
  logic ovf_evt;
  logic wr_any;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_flags;
  logic addr_take;
  logic [31:0] rd_mux;
  logic [7:0] wb;
  logic [2:0] flag_set;

  //////////////////////////////////////////////////////////////////////////
  // mode and top decode
  assign wave_mode = {ctrl_b_q[tpp_pkg::CB_WAVE_HIGH],
                      ctrl_a_q[tpp_pkg::CA_WAVE_HI:tpp_pkg::CA_WAVE_LO]};
  assign clk_sel = ctrl_b_q[tpp_pkg::CB_CS_HI:0];
  assign pc_mode = (wave_mode == tpp_pkg::WM_PC_FIXED) ||
                   (wave_mode == tpp_pkg::WM_PC_CMPA);
  assign dbuf_mode = wave_mode[0];
  assign top_val = wave_mode[2] ? compare_a_value_q
                                : tpp_pkg::CNT_MAX;

  //////////////////////////////////////////////////////////////////////////
  // prescaler tick enable, one per 1/8/64/256/1024 clocks
  always_comb
  begin
    case (clk_sel)
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (pre_q[2:0] == 3'h7);
      3'h3: timer_tick = (pre_q[5:0] == 6'h3f);
      3'h4: timer_tick = (pre_q[7:0] == 8'hff);
      3'h5: timer_tick = (pre_q[9:0] == 10'h3ff);
      default: timer_tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // counter sequence
  assign at_top = count_value_q == top_val;
  assign at_bottom = count_value_q == tpp_pkg::CNT_BOTTOM;
  always_comb
  begin
    count_value_d = count_value_q;
    up_d = up_q;
    if (wr_count)
      count_value_d = wb;
    else if (timer_tick && pc_mode)
    begin
      if (up_q && at_top)
      begin
        up_d = 1'b0; // top held one tick
        count_value_d = count_value_q - 8'h01;
      end
      else if (!up_q && at_bottom)
      begin
        up_d = 1'b1;
        count_value_d = count_value_q + 8'h01;
      end
      else if (up_q)
        count_value_d = count_value_q + 8'h01;
      else
        count_value_d = count_value_q - 8'h01;
    end
    else if (timer_tick)
    begin
      up_d = 1'b1;
      if (wave_mode[1] && at_top)
        count_value_d = tpp_pkg::CNT_BOTTOM;
      else
        count_value_d = count_value_q + 8'h01;
    end
  end
  // pc: flag at bottom; mode 7: flag at top; others: wrap from max
  assign ovf_evt = timer_tick && (pc_mode ? at_bottom && !up_q
                   : (wave_mode == 3'h7 ? at_top
                      : count_value_q == tpp_pkg::CNT_MAX));

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave decode, zero wait state
  assign addr_take = hsel && hready && (htrans == tpp_pkg::HTRANS_NONSEQ);
  assign wb = hwdata[7:0];
  assign wr_any = req_valid_q && req_q.write;
  assign wr_ctrl_a = wr_any && (req_q.addr == tpp_pkg::OFF_CTRL_A);
  assign wr_ctrl_b = wr_any && (req_q.addr == tpp_pkg::OFF_CTRL_B);
  assign wr_count = wr_any && (req_q.addr == tpp_pkg::OFF_COUNT);
  assign wr_cmp_a = wr_any && (req_q.addr == tpp_pkg::OFF_CMP_A);
  assign wr_cmp_b = wr_any && (req_q.addr == tpp_pkg::OFF_CMP_B);
  assign wr_flags = wr_any && (req_q.addr == tpp_pkg::OFF_FLAGS);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  // read mux, unmapped reads zero
  always_comb
  begin
    case (addr_take ? haddr[7:0] : 8'hff)
      tpp_pkg::OFF_CTRL_A: rd_mux = {24'h0, ctrl_a_q};
      tpp_pkg::OFF_CTRL_B: rd_mux = {24'h0, ctrl_b_q};
      tpp_pkg::OFF_COUNT: rd_mux = {24'h0, count_value_q};
      tpp_pkg::OFF_CMP_A: rd_mux = {24'h0, cmp_a_buf_q};
      tpp_pkg::OFF_CMP_B: rd_mux = {24'h0, cmp_b_buf_q};
      tpp_pkg::OFF_FLAGS: rd_mux = {29'h0, flags_q};
      default: rd_mux = 32'h0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // flag events; a set wins over a write-one clear
  assign flag_set = {timer_tick && count_value_q == compare_b_value_q,
                     timer_tick && count_value_q == compare_a_value_q,
                     ovf_evt};

  //////////////////////////////////////////////////////////////////////////
  // bus and register state
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      req_q <= '0;
      req_valid_q <= 1'b0;
      rdata_q <= 32'h0;
      ctrl_a_q <= tpp_pkg::RST_BYTE;
      ctrl_b_q <= tpp_pkg::RST_BYTE;
      cmp_a_buf_q <= tpp_pkg::RST_BYTE;
      cmp_b_buf_q <= tpp_pkg::RST_BYTE;
      flags_q <= 3'h0;
    end
    else
    begin
      req_valid_q <= addr_take && !(hsize != 3'h2);
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
      if (addr_take && !hwrite)
        rdata_q <= rd_mux;
      if (wr_ctrl_a)
        ctrl_a_q <= wb & tpp_pkg::CA_WMASK; // reserved read zero
      if (wr_ctrl_b)
        ctrl_b_q <= wb & tpp_pkg::CB_WMASK;
      if (wr_cmp_a)
        cmp_a_buf_q <= wb;
      if (wr_cmp_b)
        cmp_b_buf_q <= wb;
      flags_q <= (flags_q & ~(wr_flags ? wb[2:0] : 3'h0)) | flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter, direction, prescaler and compare buffers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      count_value_q <= tpp_pkg::CNT_BOTTOM;
      up_q <= 1'b1;
      pre_q <= '0;
      compare_a_value_q <= tpp_pkg::RST_BYTE;
      compare_b_value_q <= tpp_pkg::RST_BYTE;
    end
    else
    begin
      count_value_q <= count_value_d;
      up_q <= up_d;
      pre_q <= pre_q + 1'b1;
      if (!dbuf_mode || (timer_tick && at_top))
      begin
        compare_a_value_q <= cmp_a_buf_q;
        compare_b_value_q <= cmp_b_buf_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare output channels
  tpp_wave_unit #(.TOGGLE_OK(1'b1)) u_wave_a (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(timer_tick),
    .wave_mode(wave_mode),
    .out_mode(ctrl_a_q[tpp_pkg::CA_MODE_A_HI:tpp_pkg::CA_MODE_A_LO]),
    .cmp_val(compare_a_value_q),
    .top_val(top_val),
    .count_q(count_value_q),
    .up_q(up_q),
    .wr_cmp(wr_cmp_a),
    .wave_out(wave_out_a),
    .connected(wave_out_a_en)
  );
  tpp_wave_unit #(.TOGGLE_OK(1'b0)) u_wave_b (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(timer_tick),
    .wave_mode(wave_mode),
    .out_mode(ctrl_a_q[tpp_pkg::CA_MODE_B_HI:tpp_pkg::CA_MODE_B_LO]),
    .cmp_val(compare_b_value_q),
    .top_val(top_val),
    .count_q(count_value_q),
    .up_q(up_q),
    .wr_cmp(wr_cmp_b),
    .wave_out(wave_out_b),
    .connected(wave_out_b_en)
  );

  assign overflow_flag = flags_q[tpp_pkg::FL_OVF];
endmodule

// *** test/tpp_timer_assertions.sv ***
// Purpose: port checker for the pwm timer
// Assumes: one clock, sync active-low reset, word writes
// Notes: control writes are shadowed from the bus
`timescale 1ns/10ps
module tpp_timer_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic wave_out_a,
  input wire logic wave_out_a_en,
  input wire logic wave_out_b,
  input wire logic wave_out_b_en,
  input wire logic overflow_flag
);
  logic ph_q;
  logic wr_q;
  logic [7:0] ad_q;
  logic [7:0] sa_q;
  logic [7:0] sb_q;
  logic wa_q;
  logic [10:0] gap_q;
  logic [10:0] qt_q;
  // decode of the data phase and of steady mode 1
  wire take = hsel && hready && htrans == tpp_pkg::HTRANS_NONSEQ;
  wire wdat = ph_q && wr_q && hready;
  wire clr = wdat && ad_q == tpp_pkg::OFF_FLAGS && hwdata[0];
  wire rise = wave_out_a && !wa_q;
  wire mode1 = sa_q[7:6] == tpp_pkg::OM_CLEAR && sa_q[1:0] == 2'h1 &&
               sb_q == 8'h01;
  // address phase capture
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ph_q <= 1'b0;
    else if (hready)
      ph_q <= take;
    if (take)
      wr_q <= hwrite;
    if (take)
      ad_q <= haddr[7:0];
  end
  // shadows of the control registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      sa_q <= 8'h00;
    else if (wdat && ad_q == tpp_pkg::OFF_CTRL_A)
      sa_q <= hwdata[7:0] & tpp_pkg::CA_WMASK;
    if (!rstn)
      sb_q <= 8'h00;
    else if (wdat && ad_q == tpp_pkg::OFF_CTRL_B)
      sb_q <= hwdata[7:0] & tpp_pkg::CB_WMASK;
  end
  // cycles since last rise of a, and since last write
  always_ff @(posedge core_clk)
  begin
    wa_q <= wave_out_a;
    gap_q <= rise ? 11'h1 : gap_q + {10'h0, ~&gap_q};
    qt_q <= (!rstn || wdat) ? 11'h0 : qt_q + {10'h0, ~&qt_q};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd_data;
    ph_q && !wr_q && hready;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_ctrl_readback: assert property (
    s_rd_data ##0 ad_q == tpp_pkg::OFF_CTRL_A |-> hrdata == {24'h0, sa_q})
    else $error("control a read back wrong");
  a_unmapped_zero: assert property (
    s_rd_data ##0 ad_q > tpp_pkg::OFF_FLAGS |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_en_a_mode: assert property (
    sa_q[7:6] != 2'h1 |-> wave_out_a_en == (sa_q[7:6] != 2'h0))
    else $error("output a enable wrong");
  a_en_b_mode: assert property (
    sa_q[5:4] != 2'h1 |-> wave_out_b_en == (sa_q[5:4] != 2'h0))
    else $error("output b enable wrong");
  a_flag_sticky: assert property (
    $fell(overflow_flag) |-> $past(clr))
    else $error("overflow flag fell without clear");
  a_pc_period: assert property (
    $rose(wave_out_a) && mode1 && qt_q > 11'd1100 |-> gap_q == 11'd510)
    else $error("phase correct period wrong");
endmodule
bind tpp_timer tpp_timer_chk tpp_timer_chk_i (.core_clk(core_clk),
  .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .wave_out_a(wave_out_a), .wave_out_a_en(wave_out_a_en),
  .wave_out_b(wave_out_b), .wave_out_b_en(wave_out_b_en),
  .overflow_flag(overflow_flag));

// *** test/tpp_pin_load.sv ***
// Purpose: port pin with pulled-up load for one output
// Assumes: pin drives only when overridden and set to output
// Notes: direction bit is software's job
`timescale 1ns/10ps
module tpp_pin_load (
  input wire logic wave,
  input wire logic en,
  input wire logic dir_out,
  output logic pin
);
  // pull-up shows when the pin is not driven
  assign pin = (en && dir_out) ? wave : 1'b1;
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench for the pwm timer
// Assumes: 200 MHz core clock, zero wait-state bus
// Notes: waveforms are measured on the modelled pins
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] dir = 2'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, wa, wa_en, wb, wb_en, ovf;
  logic [1:0] pin;
  wire hready = hreadyout;
  int err_count = 0;
  int compares = 0;
  always #2.5 core_clk = ~core_clk;
  tpp_timer tpp_timer_i (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wave_out_a(wa),
    .wave_out_a_en(wa_en), .wave_out_b(wb), .wave_out_b_en(wb_en),
    .overflow_flag(ovf));
  tpp_pin_load tpp_pin_load_i [1:0] (.wave({wb, wa}),
    .en({wb_en, wa_en}), .dir_out(dir), .pin(pin));
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input int e, input int g);
    compares++;
    if (g != e)
    begin
      err_count++;
      $display("ERROR %s exp %0d got %0d", n, e, g);
    end
  endtask
  // one single bus transfer, held until hready
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= tpp_pkg::HTRANS_NONSEQ;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_lvl(input int s, input logic v);
    int n;
    n = 0;
    while (pin[s] !== v && n < 9000)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // high time and period of one pin, in cycles
  task automatic wave(input int s, input int ehi, input int eper);
    int hi;
    int per;
    hi = 0;
    wait_lvl(s, 1'b0);
    wait_lvl(s, 1'b1);
    while (pin[s] === 1'b1 && hi < 9000)
    begin
      @(negedge core_clk);
      hi++;
    end
    per = hi;
    while (pin[s] === 1'b0 && per < 9000)
    begin
      @(negedge core_clk);
      per++;
    end
    chk_cnt("high time", ehi, hi);
    chk_cnt("period", eper, per);
  endtask
  task automatic level(input int s, input int n, input int ehi);
    int hi;
    hi = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      hi += (pin[s] === 1'b1);
    end
    chk_cnt("level count", ehi, hi);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    ahb(1'b0, tpp_pkg::OFF_CTRL_A, 32'h0, q);
    chk_reg("ctrl_a reset", 32'h0, q);
    wr(tpp_pkg::OFF_CTRL_A, 32'hff);
    ahb(1'b0, tpp_pkg::OFF_CTRL_A, 32'h0, q);
    chk_reg("ctrl_a fields", 32'hf3, q);
    wr(8'h40, 32'h55);
    ahb(1'b0, 8'h40, 32'h0, q);
    chk_reg("unmapped", 32'h0, q);
    wr(tpp_pkg::OFF_CTRL_A, 32'h0);
  endtask
  task automatic t_mode1();
    wr(tpp_pkg::OFF_CMP_A, 32'h40);
    wr(tpp_pkg::OFF_CMP_B, 32'h40);
    wr(tpp_pkg::OFF_CTRL_B, 32'h01);
    wr(tpp_pkg::OFF_CTRL_A, 32'hb1);
    dir <= 2'h3;
    idle(1200);
    wave(0, 128, 510);
    wave(1, 382, 510);
  endtask
  task automatic t_ovf();
    logic [31:0] q;
    int n;
    wr(tpp_pkg::OFF_FLAGS, 32'h1);
    n = 0;
    while (ovf !== 1'b1 && n < 600)
    begin
      @(posedge core_clk);
      n++;
    end
    chk_reg("ovf set", 32'h1, {31'h0, ovf});
    wr(tpp_pkg::OFF_FLAGS, 32'h1);
    ahb(1'b0, tpp_pkg::OFF_FLAGS, 32'h0, q);
    chk_reg("ovf cleared", 32'h0, q & 32'h1);
    idle(520);
    ahb(1'b0, tpp_pkg::OFF_FLAGS, 32'h0, q);
    chk_reg("ovf again", 32'h1, q & 32'h1);
  endtask
  task automatic t_ext();
    wr(tpp_pkg::OFF_CMP_A, 32'h00);
    idle(1100);
    level(0, 600, 0);
    wr(tpp_pkg::OFF_CMP_A, 32'hff);
    idle(1100);
    level(0, 600, 600);
  endtask
  task automatic t_mode5();
    wr(tpp_pkg::OFF_CMP_A, 32'h80);
    wr(tpp_pkg::OFF_CMP_B, 32'h20);
    wr(tpp_pkg::OFF_CTRL_B, 32'h09);
    wr(tpp_pkg::OFF_CTRL_A, 32'h61);
    idle(1200);
    wave(0, 256, 512);
    wave(1, 64, 256);
  endtask
  task automatic t_pre();
    wr(tpp_pkg::OFF_CMP_A, 32'h40);
    wr(tpp_pkg::OFF_CTRL_B, 32'h02);
    wr(tpp_pkg::OFF_CTRL_A, 32'h81);
    idle(4200);
    wave(0, 1024, 4080);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_mode1();
    t_ovf();
    t_ext();
    t_mode5();
    t_pre();
    wrap_up();
  end
  // watchdog against a hung wait
  initial
  begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
endmodule
